/* hw/stm_map.svh */
// Purpose: Timing counts and error codes of the torque-off monitor
// Assumes: 100 MHz mclk; all times below in their printed unit
// Notes:   Definitions only
`ifndef STM_MAP_SVH
`define STM_MAP_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define STM_CLK_PERIOD_NS 10
`define STM_MS_NS         1000000

// ----------------------------------------
// Supervision times in ms
// ----------------------------------------
`define STM_SKEW_MAX_MS   16'h0078
`define STM_DIAG_MIN_MS   16'h00be
`define STM_DIAG_MAX_MS   16'h05c8
`define STM_DIAG_TYP_MS   16'h0276
`define STM_INTR_MS       16'h00c8
`define STM_OFF_MAX_MS    16'h0032

// ----------------------------------------
// Error codes
// ----------------------------------------
`define STM_ERR_NONE      10'h000
`define STM_ERR_REMAINS   10'h212
`define STM_ERR_INTERRUPT 10'h213
`define STM_ERR_MISSING   10'h214
`define STM_ERR_FAULT     10'h215
`define STM_ERR_NO_TRAVEL 10'h216
`define STM_ERR_DIAG      10'h3c0

`endif

/* hw/stm_pkg.sv */
// Purpose: Types shared by the torque-off monitor
// Assumes: Nothing
// Notes:   Constants live in stm_map.svh
package stm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARMED = 3'h1,
    ST_START = 3'h2,
    ST_RUN   = 3'h3,
    ST_INTR  = 3'h4,
    ST_STOP  = 3'h5,
    ST_WAIT  = 3'h6
  } stm_jstate_t;

  typedef logic [9:0] stm_err_t;

endpackage

/* hw/stm_ms_timer.sv */
// Purpose: Saturating millisecond counter
// Assumes: tick is a one-cycle pulse once per ms
// Notes:   clear wins over tick
`timescale 1ns/1ps
module stm_ms_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         clear,
  input  wire logic         tick,
  // Count
  output logic [W-1:0]      count
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (tick && (count_reg != {W{1'b1}})) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule

/* hw/stm_monitor.sv */
// Purpose: Two-channel torque-off supervision for a lift drive
// Assumes: Inputs synchronous to mclk; delay limit given in ms
// Notes:   Locked fault clears only at power-on reset
`timescale 1ns/1ps
`include "stm_map.svh"

// Summary of operation
// RULE1 - Gating allowed only with both channels on
// RULE2 - One dropped channel alone stops gating
// RULE3 - Skew over 120 ms raises error 533
// RULE4 - Persisting mismatch locks with error 960
// RULE5 - Channels compared constantly; defects shut down
// RULE6 - Diagnostic errors lock until power cycle
// RULE7 - Travel start, channels still low: 530
// RULE8 - Travel end, channels still high: 532
// RULE9 - Armed at standstill, no travel: 534
// RULE10 - Channels dropped in travel: 531 after 200ms
// RULE11 - Status output shows both channels, stage enabled
// RULE12 - No active braking; motor coasts
// RULE13 - Controller switches both channels every journey
// RULE14 - Controller drops both hourly for 1600 ms
// RULE15 - Stage blocked within 50 ms of switch-off
// RULE16 - Delay limit programmable, ms timer restarts
module stm_monitor
  import stm_pkg::*;
#(
  parameter int CYC_PER_MS = `STM_MS_NS / `STM_CLK_PERIOD_NS,
  parameter int DIAG_MS    = 630
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Enable channels and travel
  input  wire logic        torque_enable_chan_a,
  input  wire logic        torque_enable_chan_b,
  input  wire logic        travel_cmd,
  input  wire logic [15:0] travel_check_delay_limit,
  input  wire logic        hw_defect,
  // Power stage and status
  output logic             gate_enable,
  output logic             torque_off_status_out,
  output logic             locked,
  // Error report
  output logic             err_pulse,
  output logic [9:0]       err_code
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Millisecond time base
  // ----------------------------------------
  localparam int PW = $clog2(CYC_PER_MS + 1);

  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic          ms_tick;

  always_comb begin
    ms_tick  = (pre_reg == PW'(CYC_PER_MS - 1));
    pre_next = ms_tick ? '0 : pre_reg + 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // ----------------------------------------
  // Channel comparison and diagnostics
  // ----------------------------------------
  logic        both_on;
  logic        both_off;
  logic        mismatch;
  logic        fault_reg;
  logic        fault_next;
  logic        lock_reg;
  logic        lock_next;
  logic        raise_fault;
  logic        raise_lock;
  logic [15:0] skew_cnt;
  logic [15:0] diag_cnt;

  assign both_on  = torque_enable_chan_a && torque_enable_chan_b;
  assign both_off = !torque_enable_chan_a && !torque_enable_chan_b;
  assign mismatch = torque_enable_chan_a ^ torque_enable_chan_b; // RULE5

  // Skew time runs only while the channels disagree
  stm_ms_timer #(.W(16)) u_skew (
    .clk   (mclk),
    .rst_n (rst_n),
    .clear (!mismatch),
    .tick  (ms_tick),
    .count (skew_cnt)
  );

  // Diagnostic time runs only after the fault was reported
  stm_ms_timer #(.W(16)) u_diag (
    .clk   (mclk),
    .rst_n (rst_n),
    .clear (!fault_reg),
    .tick  (ms_tick),
    .count (diag_cnt)
  );

  always_comb begin
    raise_fault = mismatch && !fault_reg && !lock_reg
                  && (skew_cnt > `STM_SKEW_MAX_MS); // RULE3
    raise_lock  = !lock_reg && (hw_defect // RULE5
                  || (fault_reg && mismatch && (diag_cnt >= 16'(DIAG_MS)))); // RULE4
    fault_next  = fault_reg;
    if (raise_fault) begin
      fault_next = 1'b1;
    end else if (!mismatch) begin
      fault_next = 1'b0;
    end
    lock_next = lock_reg || raise_lock; // RULE6
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= 1'b0;
      lock_reg  <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      lock_reg  <= lock_next;
    end
  end

  // ----------------------------------------
  // Journey plausibility
  // ----------------------------------------
  stm_jstate_t st_reg;
  stm_jstate_t st_next;
  logic [15:0] jrn_cnt;
  logic [9:0]  jrn_err;
  logic        limit_hit;

  // Timer restarts whenever the journey state moves
  stm_ms_timer #(.W(16)) u_jrn (
    .clk   (mclk),
    .rst_n (rst_n),
    .clear (st_next != st_reg), // RULE16
    .tick  (ms_tick),
    .count (jrn_cnt)
  );

  assign limit_hit = (jrn_cnt >= travel_check_delay_limit); // RULE16

  always_comb begin
    st_next = st_reg;
    jrn_err = `STM_ERR_NONE;
    case (st_reg)
      ST_IDLE: begin
        if (travel_cmd) begin
          st_next = both_on ? ST_RUN : ST_START;
        end else if (both_on) begin
          st_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (travel_cmd) begin
          st_next = ST_RUN;
        end else if (!both_on) begin
          st_next = ST_IDLE;
        end else if (limit_hit) begin
          jrn_err = `STM_ERR_NO_TRAVEL; // RULE9
          st_next = ST_WAIT;
        end
      end
      ST_START: begin
        if (!travel_cmd) begin
          st_next = ST_STOP;
        end else if (both_on) begin
          st_next = ST_RUN;
        end else if (both_off && limit_hit) begin
          jrn_err = `STM_ERR_REMAINS; // RULE7
          st_next = ST_WAIT;
        end
      end
      ST_RUN: begin
        if (!travel_cmd) begin
          st_next = ST_STOP;
        end else if (!both_on) begin
          st_next = ST_INTR;
        end
      end
      ST_INTR: begin
        if (!travel_cmd) begin
          st_next = ST_STOP;
        end else if (both_on) begin
          st_next = ST_RUN;
        end else if (jrn_cnt >= `STM_INTR_MS) begin
          jrn_err = `STM_ERR_INTERRUPT; // RULE10
          st_next = ST_WAIT;
        end
      end
      ST_STOP: begin
        if (travel_cmd) begin
          st_next = ST_START;
        end else if (both_off) begin
          st_next = ST_IDLE;
        end else if (both_on && limit_hit) begin
          jrn_err = `STM_ERR_MISSING; // RULE8
          st_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!travel_cmd && both_off) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic       gate_reg;
  logic       gate_next;
  logic       status_reg;
  logic       status_next;
  logic       err_pulse_reg;
  logic       err_pulse_next;
  stm_err_t   err_code_reg;
  stm_err_t   err_code_next;

  always_comb begin
    // One cycle from inputs to gating, far inside the switch-off budget
    gate_next   = both_on && !lock_reg && !raise_lock; // RULE1 RULE2 RULE15
    status_next = gate_next; // RULE11
    // Diagnostic errors outrank journey errors in the same cycle
    err_pulse_next = 1'b1;
    if (raise_lock) begin
      err_code_next = `STM_ERR_DIAG;
    end else if (raise_fault) begin
      err_code_next = `STM_ERR_FAULT;
    end else if (jrn_err != `STM_ERR_NONE) begin
      err_code_next = jrn_err;
    end else begin
      err_pulse_next = 1'b0;
      err_code_next  = err_code_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate_reg      <= 1'b0;
      status_reg    <= 1'b0;
      err_pulse_reg <= 1'b0;
      err_code_reg  <= `STM_ERR_NONE;
    end else begin
      gate_reg      <= gate_next;
      status_reg    <= status_next;
      err_pulse_reg <= err_pulse_next;
      err_code_reg  <= err_code_next;
    end
  end

  // No brake output exists: blocked gating only lets the motor coast
  assign gate_enable           = gate_reg; // RULE12
  assign torque_off_status_out = status_reg;
  assign locked                = lock_reg;
  assign err_pulse             = err_pulse_reg;
  assign err_code              = err_code_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence fault_raised_s;
    err_pulse_reg && (err_code_reg == `STM_ERR_FAULT);
  endsequence

  sequence lock_taken_s;
    $rose(lock_reg);
  endsequence

  gate_allowed_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    (both_on && !lock_reg && !hw_defect) |=> gate_reg)
    else $error("gating not enabled with both channels on");
  single_drop_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    !(torque_enable_chan_a && torque_enable_chan_b) |=> !gate_reg)
    else $error("gating left on after a channel dropped");
  skew_fault_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    fault_raised_s |-> $past(skew_cnt) == (`STM_SKEW_MAX_MS + 16'h0001))
    else $error("skew fault at wrong time");
  diag_lock_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    lock_taken_s |-> $past(hw_defect)
      || ($past(diag_cnt) >= `STM_DIAG_MIN_MS && $past(diag_cnt) <= `STM_DIAG_MAX_MS))
    else $error("diagnostic lock outside its window");
  lock_code_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    lock_taken_s |-> err_pulse_reg && (err_code_reg == `STM_ERR_DIAG) ##1 lock_reg [*8])
    else $error("lock not reported or not held");
  locked_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    lock_reg |=> !gate_reg)
    else $error("gating while locked");
  remains_err_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
    (err_pulse_reg && err_code_reg == `STM_ERR_REMAINS)
      |-> $past(st_reg) == ST_START && $past(jrn_cnt) >= $past(travel_check_delay_limit))
    else $error("remains error without expired start");
  missing_err_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    (err_pulse_reg && err_code_reg == `STM_ERR_MISSING) |-> $past(st_reg) == ST_STOP)
    else $error("missing error outside travel end");
  no_travel_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    (err_pulse_reg && err_code_reg == `STM_ERR_NO_TRAVEL) |-> $past(st_reg) == ST_ARMED)
    else $error("travel missing error outside standstill");
  interrupt_err_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    (err_pulse_reg && err_code_reg == `STM_ERR_INTERRUPT)
      |-> $past(jrn_cnt) == `STM_INTR_MS && $past(st_reg) == ST_INTR)
    else $error("interruption error not at 200 ms");
  status_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    torque_off_status_out |-> $past(both_on) && gate_enable)
    else $error("status active without both channels");

endmodule

/* verif/stm_lift_ctrl.sv */
// Purpose: Lift controller model driving both enable relays
// Assumes: Bench calls the tasks; outputs change on rising mclk
// Notes:   A differing relay pair only when the bench asks for one
`timescale 1ns/1ps
module stm_lift_ctrl #(
  parameter int CYC_PER_MS = 10
) (
  // Clock
  input  wire logic mclk,
  // Relays and travel
  output logic      torque_enable_chan_a,
  output logic      torque_enable_chan_b,
  output logic      travel_cmd
);
  initial begin
    torque_enable_chan_a = 1'b0;
    torque_enable_chan_b = 1'b0;
    travel_cmd = 1'b0;
  end

  task automatic wait_ms(input int n);
    repeat (n * CYC_PER_MS) @(posedge mclk);
  endtask

  // Both relays move on one edge; a stuck relay is a and b differing
  task automatic set_ch(input logic a, input logic b);
    @(posedge mclk);
    torque_enable_chan_a <= a;
    torque_enable_chan_b <= b;
  endtask

  task automatic set_travel(input logic t);
    @(posedge mclk);
    travel_cmd <= t;
  endtask

  // Periodic test request, one off period only to keep runs short
  task automatic rest();
    set_ch(1'b0, 1'b0);
    wait_ms(1600);
  endtask
endmodule

/* verif/tb_stm_monitor.sv */
// Purpose: Self-checking bench of the torque-off monitor
// Assumes: ms prescaler shortened to 10 cycles
// Notes:   Error pulses are counted against the expected list
`timescale 1ns/1ps
`include "stm_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %0h exp %0h", $time, g, e); end end
module tb_stm_monitor;
  import stm_pkg::*;
  localparam int CPM = 10;
  localparam int DMS = 630;
  logic        mclk;
  logic        resetn;
  logic        hw_defect;
  logic [15:0] dly;
  stm_err_t    exp_q[$];
  stm_err_t    exp_code;
  logic        chan_a;
  logic        chan_b;
  logic        travel_cmd;
  logic        gate_enable;
  logic        torque_off_status_out;
  logic        locked;
  logic        err_pulse;
  stm_err_t    err_code;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          n_seen     = 0;
  int          n_exp      = 0;

  always #5 mclk = ~mclk;

  stm_lift_ctrl #(.CYC_PER_MS(CPM)) ctrl (
    .mclk                 (mclk),
    .torque_enable_chan_a (chan_a),
    .torque_enable_chan_b (chan_b),
    .travel_cmd           (travel_cmd)
  );

  stm_monitor #(.CYC_PER_MS(CPM), .DIAG_MS(DMS)) dut (
    .mclk                     (mclk),
    .resetn                   (resetn),
    .torque_enable_chan_a     (chan_a),
    .torque_enable_chan_b     (chan_b),
    .travel_cmd               (travel_cmd),
    .travel_check_delay_limit (dly),
    .hw_defect                (hw_defect),
    .gate_enable              (gate_enable),
    .torque_off_status_out    (torque_off_status_out),
    .locked                   (locked),
    .err_pulse                (err_pulse),
    .err_code                 (err_code)
  );

  // Unexpected error pulses show up as a count difference
  always @(posedge mclk) begin
    if (err_pulse === 1'b1) begin
      n_seen++;
      if (exp_q.size() > 0) begin
        exp_code = exp_q.pop_front();
        `CHK(err_code, exp_code)
      end
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk_gate(input logic v);
    cyc(2);
    `CHK(gate_enable, v)
    `CHK(torque_off_status_out, v)
  endtask

  task automatic expect_cyc(input stm_err_t code, input int lo, input int hi);
    int n;
    n = 0;
    exp_q.push_back(code);
    // Look off the edge so a pulse launched there is not half seen
    #1;
    while (err_pulse !== 1'b1 && n < hi) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n_exp++;
    `CHK(err_pulse, 1'b1)
    `CHK(err_code, code)
    `CHK(n >= lo, 1'b1)
    cyc(1);
  endtask

  task automatic expect_ms(input stm_err_t code, input int ms);
    expect_cyc(code, (ms - 1) * CPM - 3, (ms + 1) * CPM + 5);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    cyc(5);
    `CHK(locked, 1'b0)
    `CHK(gate_enable, 1'b0)
    `CHK(err_code, `STM_ERR_NONE)
  endtask

  task automatic summarize();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int lim;
    int v;
    mclk = 1'b0;
    resetn <= 1'b0;
    hw_defect <= 1'b0;
    void'($urandom(32'hc8bd));
    lim = 15 + ($urandom % 16);
    dly <= lim[15:0];
    do_reset();
    ctrl.set_ch(1'b1, 1'b1);
    chk_gate(1'b1);
    expect_ms(`STM_ERR_NO_TRAVEL, lim);
    ctrl.set_ch(1'b0, 1'b0);
    chk_gate(1'b0);
    ctrl.set_ch(1'b1, 1'b1);
    chk_gate(1'b1);
    ctrl.set_ch(1'b0, 1'b1);
    chk_gate(1'b0);
    ctrl.set_ch(1'b1, 1'b0);
    chk_gate(1'b0);
    ctrl.set_ch(1'b0, 1'b0);
    ctrl.set_travel(1'b1);
    expect_ms(`STM_ERR_REMAINS, lim);
    ctrl.set_travel(1'b0);
    ctrl.set_travel(1'b1);
    ctrl.wait_ms(2);
    ctrl.set_ch(1'b1, 1'b1);
    ctrl.wait_ms(3);
    ctrl.set_travel(1'b0);
    expect_ms(`STM_ERR_MISSING, lim);
    ctrl.set_ch(1'b0, 1'b0);
    ctrl.set_travel(1'b1);
    ctrl.set_ch(1'b1, 1'b1);
    ctrl.wait_ms(3);
    ctrl.set_ch(1'b0, 1'b0);
    expect_ms(`STM_ERR_INTERRUPT, 200);
    ctrl.set_travel(1'b0);
    ctrl.rest();
    // Skew past tolerance, healed before the lock
    ctrl.set_ch(1'b1, 1'b0);
    expect_ms(`STM_ERR_FAULT, 121);
    ctrl.set_ch(1'b1, 1'b1);
    ctrl.set_ch(1'b0, 1'b0);
    ctrl.wait_ms(DMS);
    `CHK(locked, 1'b0)
    ctrl.set_ch(1'b0, 1'b1);
    expect_ms(`STM_ERR_FAULT, 121);
    expect_ms(`STM_ERR_DIAG, DMS);
    `CHK(locked, 1'b1)
    ctrl.set_ch(1'b1, 1'b1);
    chk_gate(1'b0);
    ctrl.set_ch(1'b0, 1'b0);
    do_reset();
    @(posedge mclk);
    hw_defect <= 1'b1;
    @(posedge mclk);
    hw_defect <= 1'b0;
    cyc(0);
    expect_cyc(`STM_ERR_DIAG, 0, 4);
    `CHK(locked, 1'b1)
    do_reset();
    for (int i = 0; i < 8; i++) begin
      v = $urandom % 2;
      ctrl.set_ch(v[0], v[0]);
      chk_gate(v[0]);
    end
    ctrl.set_ch(1'b0, 1'b0);
    cyc(2);
    `CHK(n_seen, n_exp)
    summarize();
  end
endmodule
